// >>> verification/dtpwm_pin_model.sv
// count-source and load model standing on one shared timer pin
`timescale 1ns/100ps
module dtpwm_pin_model (
	input wire logic clk_i,
	input wire logic pin_o_i,
	input wire logic pin_oe_n_i,
	output logic pin_i_o
);
	logic src_ff = 1'b0;

	// ----------------------------------------
	// wire resolution
	// ----------------------------------------
	// the pin shows the block's level while it drives, else the source level
	assign pin_i_o = pin_oe_n_i ? src_ff : pin_o_i;

	// one level change every four clocks, slow enough for the input synchroniser
	task automatic toggle(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk_i);
			src_ff <= ~src_ff;
		end
	endtask : toggle
endmodule : dtpwm_pin_model

// >>> verification/dtpwm_top_test.sv
// self-checking bench for the dual timer pin and pwm block
`timescale 1ns/100ps
module dtpwm_top_test;
	import dtpwm_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] dat = 32'h0;
	logic [31:0] dat_o;
	logic [31:0] rdat;
	logic ack;
	logic pa_i, pa_o, pa_oe_n, pb_i, pb_o, pb_oe_n;
	logic [1:0] irq_taken = 2'h0;
	logic [1:0] timer_irq;
	int n_errors = 0;
	int checks_done = 0;

	// ----------------------------------------
	// clock, design and pin models
	// ----------------------------------------
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	dtpwm_top i_dtpwm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .shared_timer_pin_a_i(pa_i), .shared_timer_pin_a_o(pa_o),
		.shared_timer_pin_a_oe_n_o(pa_oe_n), .shared_timer_pin_b_i(pb_i),
		.shared_timer_pin_b_o(pb_o), .shared_timer_pin_b_oe_n_o(pb_oe_n),
		.irq_taken_i(irq_taken), .timer_irq_o(timer_irq));
	dtpwm_pin_model i_dtpwm_pin_model_a (.clk_i(clk_i), .pin_o_i(pa_o),
		.pin_oe_n_i(pa_oe_n), .pin_i_o(pa_i));
	dtpwm_pin_model i_dtpwm_pin_model_b (.clk_i(clk_i), .pin_o_i(pb_o),
		.pin_oe_n_i(pb_oe_n), .pin_i_o(pb_i));

	// ----------------------------------------
	// reporting
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : check
	task automatic finish_test;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic give_up;
		n_errors++;
		$display("[FAIL] %0t wait limit reached", $time);
		finish_test();
	endtask : give_up

	// ----------------------------------------
	// bus and pin helpers
	// ----------------------------------------
	// classic single cycle; the request stands until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= d;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_i);
			if (ack === 1'b1) break;
		end
		if (k == 50) give_up();
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	function automatic logic pin_out(input int ch);
		return ch ? pb_o : pa_o;
	endfunction : pin_out
	task automatic wait_pin(input int ch, input logic lvl);
		int k;
		for (k = 0; k < 500; k++) begin
			@(posedge clk_i);
			if (pin_out(ch) === lvl) break;
		end
		if (k == 500) give_up();
	endtask : wait_pin
	// counts samples at one level, starting on the first such sample
	task automatic span(input int ch, input logic lvl, output int len);
		for (len = 1; len < 500; len++) begin
			@(posedge clk_i);
			if (pin_out(ch) !== lvl) break;
		end
	endtask : span
	// three rises are taken so a stale flag cannot shorten the measured gap
	task automatic irq_gap(output int len);
		int k;
		time t0;
		for (int j = 0; j < 3; j++) begin
			for (k = 0; k < 600 && timer_irq[0] !== 1'b1; k++) @(posedge clk_i);
			if (k == 600) give_up();
			len = int'(($time - t0) / 10);
			t0 = $time;
			irq_taken <= 2'b01;
			@(posedge clk_i);
			irq_taken <= 2'b00;
			@(posedge clk_i);
			check(timer_irq[0], 1'b0);
		end
	endtask : irq_gap

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int len, run, best, seen;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check({pa_oe_n, pb_oe_n, timer_irq, ack}, 5'h18);
		wb(0, 8'h40, 0);
		check(rdat, 0);
		wb(1, 8'h20, 8'h5A);
		wb(0, 8'h20, 0);
		check(rdat, 8'h5A);
		wb(1, 8'h24, 8'h33);
		wb(0, 8'h24, 0);
		check(rdat, 0);
		// divide ratio from the instruction clock, then through the prescaler
		wb(1, 8'h1C, 8'h07);
		wb(0, 8'h1C, 0);
		check(rdat, 8'h07);
		wb(1, 8'h18, 1);
		wb(1, 8'h10, 1);
		for (int i = 0; i < 2; i++) begin
			wb(1, 8'h00, i);
			wb(1, 8'h20, i ? 1 : 9);
			wb(1, 8'h00, 4 + i);
			irq_gap(len);
			check(len, i ? 16 : 10);
			wb(1, 8'h00, i);
		end
		wb(1, 8'h30, 1);
		wb(0, 8'h20, 0);
		check(rdat, 1);
		wb(1, 8'h10, 0);
		// pin count source, both edges, both timers; flags in skip mode
		for (int i = 0; i < 4; i++) begin
			wb(1, 8'(4 * (i / 2)), 2);
			wb(1, 8'(8'h0C - 4 * (i / 2)), i % 2);
			wb(1, 8'(8'h20 + 8 * (i / 2)), 2);
			wb(0, 8'h38, 0);
			wb(1, 8'(4 * (i / 2)), 6);
			if (i / 2) i_dtpwm_pin_model_a.toggle(5);
			else i_dtpwm_pin_model_b.toggle(5);
			repeat (6) @(posedge clk_i);
			wb(0, 8'h34, 0);
			check(rdat[i / 2], i % 2);
			check(timer_irq, 0);
			if (i / 2) i_dtpwm_pin_model_a.toggle(1);
			else i_dtpwm_pin_model_b.toggle(1);
			repeat (6) @(posedge clk_i);
			wb(0, 8'h34, 0);
			check(rdat[i / 2], 1);
			wb(1, 8'(4 * (i / 2)), 2);
			wb(0, 8'h38, 0);
			check(rdat[i / 2], 1);
			wb(0, 8'h34, 0);
			check(rdat[1:0], 0);
		end
		// pwm lengths, deferred control write and stop during high
		for (int ch = 0; ch < 2; ch++) begin
			wb(1, 8'(4 * ch), 0);
			wb(1, 8'(8'h20 + 8 * ch), 3);
			wb(1, 8'(8'h24 + 8 * ch), 8'h14);
			wb(1, 8'(8'h08 + 4 * ch), 8'h08);
			wb(1, 8'(4 * ch), 8'h0C);
			wait_pin(ch, 0);
			wait_pin(ch, 1);
			check(ch ? pb_oe_n : pa_oe_n, 0);
			span(ch, 1, len);
			check(len, 21);
			span(ch, 0, len);
			check(len, 4);
			wb(1, 8'(4 * ch), 8'h08);
			wb(0, 8'h3C, 0);
			check(rdat[2 + ch], 1);
			check(pin_out(ch), 1);
			wait_pin(ch, 0);
			repeat (30) @(posedge clk_i);
			check(pin_out(ch), 0);
			wb(0, 8'h3C, 0);
			check(rdat[2 + ch], 0);
			wb(1, 8'(8'h08 + 4 * ch), 0);
			wb(1, 8'(4 * ch), 8'h0C);
			repeat (30) begin
				@(posedge clk_i);
				check({pin_out(ch), ch ? pb_oe_n : pa_oe_n}, 2'b01);
			end
			wb(1, 8'(4 * ch), 0);
			repeat (30) @(posedge clk_i);
		end
		// second pwm gated by timer one underflows every fifty clocks
		wb(1, 8'h28, 0);
		wb(1, 8'h2C, 0);
		wb(1, 8'h0C, 8'h0C);
		wb(1, 8'h04, 8'h0C);
		wb(1, 8'h20, 8'd49);
		wb(1, 8'h00, 8'h04);
		run = 0;
		best = 0;
		seen = 0;
		repeat (200) begin
			@(posedge clk_i);
			if (pb_o === 1'b1) begin
				seen = 1;
				run = 0;
			end else begin
				run++;
				if (run > best) best = run;
			end
		end
		check(seen, 1);
		check(best >= 45, 1);
		wb(1, 8'h00, 0);
		repeat (3) @(posedge clk_i);
		wb(0, 8'h3C, 0);
		check(rdat[4], 1);
		seen = 0;
		repeat (20) begin
			@(posedge clk_i);
			if (pb_o === 1'b1) seen = 1;
		end
		check(seen, 1);
		// count source off holds the count while run is set
		wb(1, 8'h20, 8'h05);
		wb(1, 8'h00, 8'h07);
		repeat (20) @(posedge clk_i);
		wb(1, 8'h00, 8'h03);
		wb(0, 8'h20, 0);
		check(rdat, 8'h05);
		// timer two in interrupt mode: skip leaves its flag, irq taken clears it
		wb(1, 8'h04, 0);
		wb(1, 8'h14, 1);
		@(posedge clk_i);
		check(timer_irq, 2'h2);
		wb(0, 8'h38, 0);
		check(rdat[1], 1);
		wb(0, 8'h34, 0);
		check(rdat[1:0], 2'h2);
		irq_taken <= 2'h2;
		@(posedge clk_i);
		irq_taken <= 2'h0;
		@(posedge clk_i);
		check(timer_irq, 2'h0);
		finish_test();
	end
endmodule : dtpwm_top_test

// >>> verilog/dtpwm_defines.svh
// register offsets, field positions and reset values of the dual timer pin block
`ifndef DTPWM_DEFINES_SVH
`define DTPWM_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DTPWM_ADR_CTRL1 8'h00
`define DTPWM_ADR_CTRL2 8'h04
`define DTPWM_ADR_PINA 8'h08
`define DTPWM_ADR_PINB 8'h0C
`define DTPWM_ADR_IRQ1 8'h10
`define DTPWM_ADR_IRQ2 8'h14
`define DTPWM_ADR_PSRUN 8'h18
`define DTPWM_ADR_PSLOAD 8'h1C
`define DTPWM_ADR_T1LOAD 8'h20
`define DTPWM_ADR_T1HIGH 8'h24
`define DTPWM_ADR_T2LOAD 8'h28
`define DTPWM_ADR_T2HIGH 8'h2C
`define DTPWM_ADR_RESTORE 8'h30
`define DTPWM_ADR_FLAGS 8'h34
`define DTPWM_ADR_SKIP 8'h38
`define DTPWM_ADR_STATUS 8'h3C

// ----------------------------------------
// field positions
// ----------------------------------------
`define DTPWM_SRC_LO 0
`define DTPWM_SRC_HI 1
`define DTPWM_BIT_RUN 2
`define DTPWM_BIT_PWM 3
`define DTPWM_BIT_EDGE 0
`define DTPWM_BIT_GATE 2
`define DTPWM_BIT_PINF 3
`define DTPWM_BIT_PSRUN 0
`define DTPWM_BIT_IEN 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define DTPWM_RST_CTRL 4'h0
`define DTPWM_RST_GATE 1'b1

`endif

// >>> verilog/dtpwm_pkg.sv
// types shared by the dual timer pin block
package dtpwm_pkg;
	// count source selection, low two bits of a timer control register
	typedef enum logic [1:0] {
		DTPWM_SRC_CLK = 2'h0,
		DTPWM_SRC_PS = 2'h1,
		DTPWM_SRC_PIN = 2'h2,
		DTPWM_SRC_OFF = 2'h3
	} dtpwm_src_t;
	typedef logic [3:0] dtpwm_ctrl_t;
endpackage : dtpwm_pkg

// >>> verilog/dtpwm_timer.sv
// one auto-reload down counter with low/high reload pair for pwm
`timescale 1ns/100ps
module dtpwm_timer
	import dtpwm_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	dtpwm_tmr_if.tmr tb
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] low_rl_ff;
	logic [W-1:0] high_rl_ff;
	logic high_ff;
	logic uf;

	// underflow is the count pulse that finds zero
	assign uf = tb.run & tb.tick & (cnt_ff == '0);
	assign tb.underflow = uf;
	assign tb.count = cnt_ff;
	assign tb.pwm_high = high_ff;

	// ----------------------------------------
	// counter and reload pair
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= '0;
			low_rl_ff <= '0;
		end else if (tb.load) begin
			cnt_ff <= tb.wdata;
			low_rl_ff <= tb.wdata;
		end else if (tb.restore) begin
			cnt_ff <= low_rl_ff;
		end else if (uf) begin
			// alternate reloads give the low and high lengths
			if (tb.pwm_mode && !high_ff) begin
				cnt_ff <= high_rl_ff;
			end else begin
				cnt_ff <= low_rl_ff;
			end
		end else if (tb.run && tb.tick) begin
			cnt_ff <= cnt_ff - W'(1);
		end
	end

	// high reload may be written while running
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			high_rl_ff <= '0;
		end else if (tb.high_wr) begin
			high_rl_ff <= tb.wdata;
		end
	end

	// pwm phase flips on each underflow while pwm is on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			high_ff <= 1'b0;
		end else if (tb.load || tb.restore) begin
			high_ff <= 1'b0;
		end else if (uf) begin
			high_ff <= tb.pwm_mode & ~high_ff;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	pwm_reload_high_a: assert property (
		uf && tb.pwm_mode && !high_ff && !tb.load && !tb.restore && !tb.high_wr
		|=> high_ff && cnt_ff == high_rl_ff)
		else $error("pwm did not enter the high phase with the high reload");

	count_step_a: assert property (
		tb.run && tb.tick && cnt_ff != '0 && !tb.load && !tb.restore
		|=> cnt_ff == $past(cnt_ff) - W'(1))
		else $error("counter did not step down by one");
endmodule : dtpwm_timer

// >>> verilog/dtpwm_tmr_if.sv
// link between the pin/control logic and one timer channel
`timescale 1ns/100ps
interface dtpwm_tmr_if #(
	parameter int W = 8
);
	logic tick;
	logic run;
	logic pwm_mode;
	logic load;
	logic restore;
	logic high_wr;
	logic [W-1:0] wdata;
	logic [W-1:0] count;
	logic underflow;
	logic pwm_high;
	modport ctl (
		output tick, run, pwm_mode, load, restore, high_wr, wdata,
		input count, underflow, pwm_high
	);
	modport tmr (
		input tick, run, pwm_mode, load, restore, high_wr, wdata,
		output count, underflow, pwm_high
	);
endinterface : dtpwm_tmr_if

// >>> verilog/dtpwm_top.sv
// dual 8-bit timer pin selection, pwm output and underflow flags
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`include "dtpwm_defines.svh"

module dtpwm_top
	import dtpwm_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic shared_timer_pin_a_i,
	output logic shared_timer_pin_a_o,
	output logic shared_timer_pin_a_oe_n_o,
	input wire logic shared_timer_pin_b_i,
	output logic shared_timer_pin_b_o,
	output logic shared_timer_pin_b_oe_n_o,
	input wire logic [1:0] irq_taken_i,
	output logic [1:0] timer_irq_o
);
	// ----------------------------------------
	// elaboration check
	// ----------------------------------------
	generate
		if (W < 2 || W > 8) begin : g_bad_w
			$error("timer width must be 2 to 8 bits");
		end
	endgenerate

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	dtpwm_ctrl_t ctrl_ff [2];
	dtpwm_ctrl_t pend_val_ff [2];
	logic [1:0] pend_ff;
	dtpwm_ctrl_t pin_a_ctrl_ff;
	dtpwm_ctrl_t pin_b_ctrl_ff;
	logic [1:0] irq_en_ff;
	logic ps_run_ff;
	logic [W-1:0] ps_cnt_ff;
	logic [W-1:0] ps_rl_ff;
	logic ps_tick;
	logic [1:0] flag_ff;
	logic [1:0] nxt_flag;
	logic gate_ff;
	logic [1:0] sync1_ff;
	logic [1:0] sync2_ff;
	logic [1:0] prev_ff;
	logic [1:0] pin_edge;
	logic [1:0] uf;
	logic [1:0] high;
	logic [1:0] tick;
	logic [W-1:0] cnt [2];
	logic ack_ff;
	logic [31:0] dat_ff;
	logic acc;
	logic take;
	logic [7:0] wadr;
	logic [7:0] rdata;
	logic [1:0] wr_ctrl;
	logic [1:0] wr_load;
	logic [1:0] wr_high;
	logic [1:0] restore;
	logic skip_rd;
	logic [1:0] edge_sel;

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	// one wait state: data is registered and the write commits with ack
	assign acc = wb_cyc_i & wb_stb_i;
	assign take = acc & ack_ff;
	assign wadr = {wb_adr_i[7:2], 2'h0};
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= acc & ~ack_ff;
		end
	end

	// read data is captured in the request cycle and stands with ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_ff <= 32'h0;
		end else if (acc && !ack_ff) begin
			dat_ff <= {24'h0, rdata};
		end
	end

	// write strobes, byte lane 0 only; upper lanes hold no bits
	always_comb begin
		wr_ctrl = 2'h0;
		wr_load = 2'h0;
		wr_high = 2'h0;
		restore = 2'h0;
		if (take && wb_we_i && wb_sel_i[0]) begin
			case (wadr)
				`DTPWM_ADR_CTRL1: wr_ctrl[0] = 1'b1;
				`DTPWM_ADR_CTRL2: wr_ctrl[1] = 1'b1;
				`DTPWM_ADR_T1LOAD: wr_load[0] = 1'b1;
				`DTPWM_ADR_T2LOAD: wr_load[1] = 1'b1;
				`DTPWM_ADR_T1HIGH: wr_high[0] = 1'b1;
				`DTPWM_ADR_T2HIGH: wr_high[1] = 1'b1;
				`DTPWM_ADR_RESTORE: restore = wb_dat_i[1:0];
				default: wr_ctrl = 2'h0;
			endcase
		end
	end

	// a read of the skip register acts as the skip test
	assign skip_rd = take & ~wb_we_i & (wadr == `DTPWM_ADR_SKIP);

	// read mux; unmapped words answer zero
	always_comb begin
		rdata = 8'h0;
		case (wadr)
			`DTPWM_ADR_CTRL1: rdata = {4'h0, ctrl_ff[0]};
			`DTPWM_ADR_CTRL2: rdata = {4'h0, ctrl_ff[1]};
			`DTPWM_ADR_PINA: rdata = {4'h0, pin_a_ctrl_ff};
			`DTPWM_ADR_PINB: rdata = {4'h0, pin_b_ctrl_ff};
			`DTPWM_ADR_IRQ1: rdata = {7'h0, irq_en_ff[0]};
			`DTPWM_ADR_IRQ2: rdata = {7'h0, irq_en_ff[1]};
			`DTPWM_ADR_PSRUN: rdata = {7'h0, ps_run_ff};
			`DTPWM_ADR_PSLOAD: rdata = 8'(ps_rl_ff);
			`DTPWM_ADR_T1LOAD: rdata = 8'(cnt[0]);
			`DTPWM_ADR_T2LOAD: rdata = 8'(cnt[1]);
			`DTPWM_ADR_FLAGS: rdata = {6'h0, flag_ff};
			`DTPWM_ADR_SKIP: rdata = {6'h0, flag_ff};
			`DTPWM_ADR_STATUS: rdata = {3'h0, gate_ff, pend_ff, high};
			default: rdata = 8'h0;
		endcase
	end

	// ----------------------------------------
	// pin and interrupt control registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_a_ctrl_ff <= `DTPWM_RST_CTRL;
			pin_b_ctrl_ff <= `DTPWM_RST_CTRL;
			irq_en_ff <= 2'h0;
		end else if (take && wb_we_i && wb_sel_i[0]) begin
			case (wadr)
				`DTPWM_ADR_PINA: pin_a_ctrl_ff <= wb_dat_i[3:0];
				`DTPWM_ADR_PINB: pin_b_ctrl_ff <= wb_dat_i[3:0];
				`DTPWM_ADR_IRQ1: irq_en_ff[0] <= wb_dat_i[`DTPWM_BIT_IEN];
				`DTPWM_ADR_IRQ2: irq_en_ff[1] <= wb_dat_i[`DTPWM_BIT_IEN];
				default: irq_en_ff <= irq_en_ff;
			endcase
		end
	end

	// ----------------------------------------
	// prescaler on the instruction clock
	// ----------------------------------------
	assign ps_tick = ps_run_ff & (ps_cnt_ff == '0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ps_run_ff <= 1'b0;
			ps_cnt_ff <= '0;
			ps_rl_ff <= '0;
		end else begin
			if (take && wb_we_i && wb_sel_i[0] && wadr == `DTPWM_ADR_PSRUN) begin
				ps_run_ff <= wb_dat_i[`DTPWM_BIT_PSRUN];
			end
			// loading a running prescaler is not guarded
			if (take && wb_we_i && wb_sel_i[0] && wadr == `DTPWM_ADR_PSLOAD) begin
				ps_cnt_ff <= wb_dat_i[W-1:0];
				ps_rl_ff <= wb_dat_i[W-1:0];
			end else if (ps_tick) begin
				ps_cnt_ff <= ps_rl_ff;
			end else if (ps_run_ff) begin
				ps_cnt_ff <= ps_cnt_ff - W'(1);
			end
		end
	end

	// ----------------------------------------
	// pin input synchronisers and edge pick
	// ----------------------------------------
	// index 0 is pin a, index 1 is pin b
	assign edge_sel = {pin_b_ctrl_ff[`DTPWM_BIT_EDGE], pin_a_ctrl_ff[`DTPWM_BIT_EDGE]};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_ff <= 2'h0;
			sync2_ff <= 2'h0;
			prev_ff <= 2'h0;
		end else begin
			sync1_ff <= {shared_timer_pin_b_i, shared_timer_pin_a_i};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	// edge bit one picks rising, zero picks falling
	assign pin_edge = (edge_sel & sync2_ff & ~prev_ff)
		| (~edge_sel & ~sync2_ff & prev_ff);

	// ----------------------------------------
	// timer channels
	// ----------------------------------------
	generate
		for (genvar i = 0; i < 2; i++) begin : g_ch
			dtpwm_tmr_if #(.W(W)) tif ();
			dtpwm_src_t src;

			assign src = dtpwm_src_t'(ctrl_ff[i][`DTPWM_SRC_HI:`DTPWM_SRC_LO]);

			// timer one takes pin b, timer two takes pin a
			always_comb begin
				case (src)
					DTPWM_SRC_CLK: tick[i] = 1'b1;
					DTPWM_SRC_PS: tick[i] = ps_tick;
					DTPWM_SRC_PIN: tick[i] = pin_edge[1-i];
					default: tick[i] = 1'b0;
				endcase
			end

			assign tif.tick = tick[i];
			assign tif.run = ctrl_ff[i][`DTPWM_BIT_RUN];
			assign tif.pwm_mode = ctrl_ff[i][`DTPWM_BIT_PWM];
			assign tif.load = wr_load[i];
			assign tif.restore = restore[i];
			assign tif.high_wr = wr_high[i];
			assign tif.wdata = wb_dat_i[W-1:0];
			assign uf[i] = tif.underflow;
			assign high[i] = tif.pwm_high;
			assign cnt[i] = tif.count;

			dtpwm_timer #(.W(W)) u_tmr (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.tb(tif.tmr)
			);

			// control writes, and hence stops, wait out a pwm high phase
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					ctrl_ff[i] <= `DTPWM_RST_CTRL;
					pend_ff[i] <= 1'b0;
					pend_val_ff[i] <= `DTPWM_RST_CTRL;
				end else if (wr_ctrl[i]) begin
					if (high[i]) begin
						pend_ff[i] <= 1'b1;
						pend_val_ff[i] <= wb_dat_i[3:0];
					end else begin
						ctrl_ff[i] <= wb_dat_i[3:0];
						pend_ff[i] <= 1'b0;
					end
				end else if (pend_ff[i] && !high[i]) begin
					ctrl_ff[i] <= pend_val_ff[i];
					pend_ff[i] <= 1'b0;
				end
			end

			ctrl_defer_a: assert property (@(posedge clk_i) disable iff (rst_i)
				wr_ctrl[i] && high[i] |=> pend_ff[i] && ctrl_ff[i] == $past(ctrl_ff[i]))
				else $error("control write was not held during pwm high");

			flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
				uf[i] |=> flag_ff[i])
				else $error("underflow did not set its flag");

			skip_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
				skip_rd && flag_ff[i] && !irq_en_ff[i] && !uf[i] |=> !flag_ff[i])
				else $error("skip test did not clear the flag");
		end
	endgenerate

	// ----------------------------------------
	// underflow flags
	// ----------------------------------------
	// a new underflow wins over a clear in the same cycle
	always_comb begin
		nxt_flag = uf;
		for (int k = 0; k < 2; k++) begin
			if (!(irq_taken_i[k] || (skip_rd && !irq_en_ff[k]))) begin
				nxt_flag[k] = nxt_flag[k] | flag_ff[k];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_ff <= 2'h0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	// request lines to the core only in interrupt mode
	assign timer_irq_o = flag_ff & irq_en_ff;

	// ----------------------------------------
	// second pwm gate driven by timer one
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_ff <= `DTPWM_RST_GATE;
		end else if (!ctrl_ff[0][`DTPWM_BIT_RUN]) begin
			gate_ff <= `DTPWM_RST_GATE;
		end else if (pin_b_ctrl_ff[`DTPWM_BIT_GATE] && uf[0]) begin
			gate_ff <= ~gate_ff;
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	// output enables are low while the pin carries pwm
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shared_timer_pin_a_o <= 1'b0;
			shared_timer_pin_a_oe_n_o <= 1'b1;
			shared_timer_pin_b_o <= 1'b0;
			shared_timer_pin_b_oe_n_o <= 1'b1;
		end else begin
			shared_timer_pin_a_oe_n_o <= ~pin_a_ctrl_ff[`DTPWM_BIT_PINF];
			shared_timer_pin_a_o <= pin_a_ctrl_ff[`DTPWM_BIT_PINF] & high[0];
			shared_timer_pin_b_oe_n_o <= ~pin_b_ctrl_ff[`DTPWM_BIT_PINF];
			shared_timer_pin_b_o <= pin_b_ctrl_ff[`DTPWM_BIT_PINF] & high[1]
				& (gate_ff | ~pin_b_ctrl_ff[`DTPWM_BIT_GATE]);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	pin_a_pwm_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pin_a_ctrl_ff[`DTPWM_BIT_PINF] |=> !shared_timer_pin_a_oe_n_o
		&& shared_timer_pin_a_o == $past(high[0]))
		else $error("pin a does not carry the first pwm");

	pin_b_input_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pin_b_ctrl_ff[`DTPWM_BIT_PINF] |=> shared_timer_pin_b_oe_n_o
		&& !shared_timer_pin_b_o)
		else $error("pin b driven while selected as count input");

	gate_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_ff[0][`DTPWM_BIT_RUN] && pin_b_ctrl_ff[`DTPWM_BIT_GATE] && uf[0]
		|=> gate_ff != $past(gate_ff))
		else $error("second pwm gate did not toggle on timer one underflow");

	pin_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_ff[0][`DTPWM_SRC_HI:`DTPWM_SRC_LO] == DTPWM_SRC_PIN
		|-> tick[0] == pin_edge[1])
		else $error("timer one does not follow pin b edges");

	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		acc && !ack_ff |=> ack_ff ##1 !ack_ff)
		else $error("wishbone ack not a single cycle after request");
endmodule : dtpwm_top
